// ===== design/nva_pkg.sv
// ---------------------------------------------------------------
// nonvolatile byte array access: shared constants and types
// ---------------------------------------------------------------
package nva_pkg;

  // ---------------------------------------------------------------
  // array geometry
  // ---------------------------------------------------------------
  localparam int NVA_DEPTH = 512;   // bytes in the array
  localparam int NVA_AW = 9;        // linear address width

  // ---------------------------------------------------------------
  // i/o register offsets (6-bit i/o space)
  // ---------------------------------------------------------------
  localparam logic [5:0] OFS_CONTROL = 6'h1f;
  localparam logic [5:0] OFS_DATA = 6'h20;    // data register slot
  localparam logic [5:0] OFS_ADDR_LOW = 6'h21;
  localparam logic [5:0] OFS_ADDR_HIGH = 6'h22;

  // ---------------------------------------------------------------
  // control register bit positions
  // ---------------------------------------------------------------
  localparam int BIT_READ_STROBE = 0;
  localparam int BIT_WRITE_STROBE = 1;
  localparam int BIT_MASTER_WE = 2;
  localparam int BIT_READY_IRQ_EN = 3;

  // reset values
  localparam logic [7:0] CONTROL_RST = 8'h00;
  localparam logic [7:0] DATA_RST = 8'h00;
  localparam logic [8:0] ADDR_RST = 9'h000;

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam logic [2:0] MWE_CYCLES = 3'h4;        // master enable lifetime
  localparam logic [2:0] READ_STALL_CYCLES = 3'h4; // core halt on read
  localparam logic [2:0] WRITE_STALL_CYCLES = 3'h2; // core halt on write start
  localparam int CLK_PERIOD_NS = 10;               // 100 MHz system clock
  localparam int WRITE_TIME_NS = 3300000;          // typical 3.3 ms program time
  localparam int WRITE_RC_CYCLES_DEF = 27072;      // calibrated rc cycles per write
  localparam int WRITE_CLK_CYCLES = WRITE_TIME_NS / CLK_PERIOD_NS;
  // rc oscillator emulated as an enable pulse every rc_div system clocks
  localparam int RC_DIV_DEF = WRITE_CLK_CYCLES / WRITE_RC_CYCLES_DEF;

  // ---------------------------------------------------------------
  // carriers
  // ---------------------------------------------------------------
  typedef struct packed {
    logic wr;          // i/o write strobe, one cycle
    logic rd;          // i/o read strobe, one cycle
    logic [5:0] addr;  // i/o register address
    logic [7:0] wdata; // write data
  } nva_io_req_t;

  // programming state
  typedef enum logic {
    NVA_IDLE = 1'b0,
    NVA_PROG = 1'b1
  } nva_state_t;

endpackage : nva_pkg

// ===== design/nva_access.sv
`timescale 1ns/1ps
module nva_access #(
  parameter int RC_DIV = nva_pkg::RC_DIV_DEF,
  parameter int WRITE_RC_CYCLES = nva_pkg::WRITE_RC_CYCLES_DEF
) (
  // clock and reset
  input wire logic clock,
  input wire logic sys_rst,
  // i/o register port
  input wire nva_pkg::nva_io_req_t io_req,
  output logic [7:0] io_rdata,
  // core side
  input wire logic global_irq_enable,
  output logic cpu_stall,
  output logic ready_irq
);
  import nva_pkg::*;

  // ---------------------------------------------------------------
  // storage and registers
  // ---------------------------------------------------------------
  logic [7:0] mem_q [0:NVA_DEPTH-1];   // the byte array itself
  logic [NVA_AW-1:0] addr_q;           // nv_address
  logic [7:0] data_q;                  // nv_data
  logic irq_en_q;                      // ready_irq_enable
  logic mwe_q;                         // master_write_enable
  logic [2:0] mwe_cnt_q;               // master enable lifetime count
  logic [2:0] stall_cnt_q;             // remaining halt cycles
  logic [15:0] rc_div_q;               // rc tick divider
  logic [15:0] prog_cnt_q;             // rc cycles left in programming
  nva_state_t state_q;
  nva_state_t state_d;

  // ---------------------------------------------------------------
  // decode
  // ---------------------------------------------------------------
  wire busy = (state_q == NVA_PROG);
  wire wr_ctrl = io_req.wr && (io_req.addr == OFS_CONTROL);
  wire wr_data = io_req.wr && (io_req.addr == OFS_DATA);
  wire wr_alo = io_req.wr && (io_req.addr == OFS_ADDR_LOW);
  wire wr_ahi = io_req.wr && (io_req.addr == OFS_ADDR_HIGH);
  // enable bit written as one arms the window
  wire set_mwe = wr_ctrl && io_req.wdata[BIT_MASTER_WE];
  // strobe needs enable already set
  // a strobe in the same write that sets the enable is refused
  wire write_go = wr_ctrl && io_req.wdata[BIT_WRITE_STROBE] && mwe_q && !busy;
  // reads blocked while programming
  // a refused read leaves data and halt untouched
  wire read_go = wr_ctrl && io_req.wdata[BIT_READ_STROBE] && !busy;
  // one-cycle pulse standing in for an rc oscillator edge
  wire rc_tick = (rc_div_q == 16'h0000);
  // last rc cycle of the program time
  wire prog_done = busy && rc_tick && (prog_cnt_q == 16'h0001);
  // array output seen through the address register
  wire [7:0] rd_byte = mem_q[addr_q];
  wire [15:0] prog_len = 16'(WRITE_RC_CYCLES);
  wire [15:0] rc_reload = 16'(RC_DIV - 1);

  // ---------------------------------------------------------------
  // read-back mux
  // ---------------------------------------------------------------
  // reserved bits forced to zero
  // busy shown as strobe
  // the read strobe position never holds a one
  wire [7:0] ctrl_view = {4'h0, irq_en_q, mwe_q, busy, 1'b0};
  // only the top address bit lives here
  wire [7:0] ahi_view = {7'h00, addr_q[8]};
  // live mux: read data follows the offset every cycle
  always_comb begin
    case (io_req.addr)
      OFS_CONTROL: io_rdata = ctrl_view;
      OFS_DATA: io_rdata = data_q;
      OFS_ADDR_LOW: io_rdata = addr_q[7:0];
      OFS_ADDR_HIGH: io_rdata = ahi_view;
      // unmapped offsets read as zero
      default: io_rdata = 8'h00;
    endcase
  end

  // ---------------------------------------------------------------
  // programming state machine
  // ---------------------------------------------------------------
  // strobe drops when time is up
  always_comb begin
    state_d = state_q;
    // hold unless a start or the last tick moves it
    case (state_q)
      NVA_IDLE: if (write_go) state_d = NVA_PROG;
      NVA_PROG: if (prog_done) state_d = NVA_IDLE;
      default: state_d = NVA_IDLE;
    endcase
  end

  // state register
  // a reset in mid-write ends the busy window at once; the byte
  // is already committed, so the array never holds a torn value
  always_ff @(posedge clock) begin
    if (sys_rst) state_q <= NVA_IDLE;
    else state_q <= state_d;
  end

  // ---------------------------------------------------------------
  // rc oscillator emulation
  // ---------------------------------------------------------------
  // free-running divider; a write may start mid-period, so the
  // first rc cycle is short by up to rc_div-1 clocks
  always_ff @(posedge clock) begin
    if (sys_rst || rc_tick) rc_div_q <= rc_reload;
    else rc_div_q <= rc_div_q - 16'h0001;
  end

  // count rc cycles while programming
  // reload on a start, then one step per rc tick
  always_ff @(posedge clock) begin
    if (sys_rst) prog_cnt_q <= 16'h0000;
    else if (write_go) prog_cnt_q <= prog_len;
    else if (busy && rc_tick) prog_cnt_q <= prog_cnt_q - 16'h0001;
  end

  // ---------------------------------------------------------------
  // array access
  // ---------------------------------------------------------------
  // byte committed at the accepted strobe
  // the cell is shown busy for the whole program time, which
  // hides the early commit from software
  always_ff @(posedge clock) begin
    if (write_go) mem_q[addr_q] <= data_q;
  end

  // read data lands in data register
  always_ff @(posedge clock) begin
    if (sys_rst) data_q <= DATA_RST;
    else if (read_go) data_q <= rd_byte;
    else if (wr_data) data_q <= io_req.wdata;
  end

  always_ff @(posedge clock) begin
    if (sys_rst) addr_q <= ADDR_RST;
    else if (wr_alo && !busy) addr_q[7:0] <= io_req.wdata;
    else if (wr_ahi && !busy) addr_q[8] <= io_req.wdata[0];
  end

  // ---------------------------------------------------------------
  // control bits
  // ---------------------------------------------------------------
  // enable bit is plain read/write
  // every control write updates it; no bit-set semantics
  always_ff @(posedge clock) begin
    if (sys_rst) irq_en_q <= CONTROL_RST[BIT_READY_IRQ_EN];
    else if (wr_ctrl) irq_en_q <= io_req.wdata[BIT_READY_IRQ_EN];
  end

  // master enable times out
  // a software set wins over the timeout in the same cycle
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      mwe_q <= CONTROL_RST[BIT_MASTER_WE];
      mwe_cnt_q <= 3'h0;
    end else if (set_mwe) begin
      mwe_q <= 1'b1;
      mwe_cnt_q <= MWE_CYCLES;
    end else if (mwe_cnt_q != 3'h0) begin
      // last step of the count drops the enable
      mwe_cnt_q <= mwe_cnt_q - 3'h1;
      mwe_q <= (mwe_cnt_q != 3'h1);
    end
  end

  // ---------------------------------------------------------------
  // core halt and ready interrupt
  // ---------------------------------------------------------------
  // four halt cycles after a read
  // two halt cycles after a write start
  // a read load wins when both strobes share one write
  always_ff @(posedge clock) begin
    if (sys_rst) stall_cnt_q <= 3'h0;
    else if (read_go) stall_cnt_q <= READ_STALL_CYCLES;
    else if (write_go) stall_cnt_q <= WRITE_STALL_CYCLES;
    else if (stall_cnt_q != 3'h0) stall_cnt_q <= stall_cnt_q - 3'h1;
  end

  // halt straight from the counter; no extra flop delay
  assign cpu_stall = (stall_cnt_q != 3'h0);

  assign ready_irq = irq_en_q && global_irq_enable && !busy;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  // clocks spent busy in the current write, for the length check
  logic [31:0] busy_len_q;
  always_ff @(posedge clock) begin
    if (sys_rst || write_go) busy_len_q <= 32'h0000_0000;
    else if (busy) busy_len_q <= busy_len_q + 32'h0000_0001;
  end

  // a fresh set must hold for four cycles
  mwe_lifetime_a: assert property (
    @(posedge clock) disable iff (sys_rst)
    set_mwe |=> mwe_q [*4])
    else $error("master enable lifetime wrong");

  // with no new set, the enable is gone on the fifth cycle
  mwe_timeout_a: assert property (
    @(posedge clock) disable iff (sys_rst)
    set_mwe ##1 (!set_mwe) [*4] |=> !mwe_q)
    else $error("master enable did not time out");

  write_window_a: assert property (
    @(posedge clock) disable iff (sys_rst)
    $rose(busy) |-> $past(mwe_cnt_q) != 3'h0)
    else $error("write started outside enable window");

  write_refused_a: assert property (
    @(posedge clock) disable iff (sys_rst)
    (wr_ctrl && io_req.wdata[BIT_WRITE_STROBE] && !mwe_q && !busy) |=> !busy)
    else $error("unarmed strobe started a write");

  write_guard_a: assert property (
    @(posedge clock) disable iff (sys_rst)
    $rose(busy) |-> $past(mwe_q) && $past(wr_ctrl))
    else $error("write started without master enable");

  // ---------------------------------------------------------------
  // halt checks
  // ---------------------------------------------------------------
  read_stall_a: assert property (
    @(posedge clock) disable iff (sys_rst)
    read_go |=> cpu_stall [*4] ##1 (!cpu_stall || $past(read_go || write_go)))
    else $error("read halt length wrong");

  write_stall_a: assert property (
    @(posedge clock) disable iff (sys_rst)
    (write_go && !read_go) |=> cpu_stall [*2] ##1 (!cpu_stall || $past(read_go)))
    else $error("write halt length wrong");

  // ---------------------------------------------------------------
  // interrupt checks
  // ---------------------------------------------------------------
  irq_busy_a: assert property (
    @(posedge clock) disable iff (sys_rst)
    (irq_en_q && global_irq_enable) |-> (ready_irq != busy))
    else $error("ready interrupt level wrong");

  // ---------------------------------------------------------------
  // data path checks
  // ---------------------------------------------------------------
  read_data_a: assert property (
    @(posedge clock) disable iff (sys_rst)
    read_go |=> data_q == $past(rd_byte))
    else $error("read data not captured");

  // the byte lands at the address held when the strobe was taken
  write_commit_a: assert property (
    @(posedge clock) disable iff (sys_rst)
    write_go |=> mem_q[$past(addr_q)] == $past(data_q))
    else $error("write data not committed");

  // a refused read must not touch the data register
  read_refused_a: assert property (
    @(posedge clock) disable iff (sys_rst)
    (busy && wr_ctrl && io_req.wdata[BIT_READ_STROBE]) |=> $stable(data_q))
    else $error("read went through during a write");

  addr_hold_a: assert property (
    @(posedge clock) disable iff (sys_rst)
    (busy && $past(busy)) |-> $stable(addr_q))
    else $error("address moved during write");

  prog_end_a: assert property (
    @(posedge clock) disable iff (sys_rst)
    $fell(busy) |-> $past(prog_cnt_q) == 16'h0001 && $past(rc_tick))
    else $error("programming ended early");

  strobe_view_a: assert property (
    @(posedge clock) disable iff (sys_rst)
    (io_req.addr == OFS_CONTROL) |-> io_rdata[BIT_WRITE_STROBE] == busy && io_rdata[7:4] == 4'h0)
    else $error("control read-back wrong");

  addr_view_a: assert property (
    @(posedge clock) disable iff (sys_rst)
    (io_req.addr == OFS_ADDR_HIGH) |-> io_rdata[7:1] == 7'h00)
    else $error("address high read-back wrong");

  // program time in clocks, allowing for a short first rc cycle
  prog_len_a: assert property (
    @(posedge clock) disable iff (sys_rst)
    ($fell(busy) && !$past(sys_rst)) |->
      busy_len_q >= 32'((WRITE_RC_CYCLES - 1) * RC_DIV + 1) &&
      busy_len_q <= 32'(WRITE_RC_CYCLES * RC_DIV))
    else $error("program time wrong");

endmodule : nva_access

// ===== bench/nva_tb.sv
`timescale 1ns/1ps
module tb;
  import nva_pkg::*;
  // ---------------------------------------------------------------
  // stimulus, design hookup and bookkeeping
  // ---------------------------------------------------------------
  logic clock = 1'b0; // 100 MHz system clock
  logic sys_rst = 1'b1; // synchronous, active high
  nva_io_req_t io_req = '0; // register port request
  logic global_irq_enable = 1'b0;
  logic [7:0] io_rdata;
  logic cpu_stall;
  logic ready_irq;
  int n_errors = 0;
  int comparisons = 0;
  int cycles = 0; // hang guard
  always #5 clock = ~clock;
  // short program time keeps the run brief; busy window is about 8 clocks
  nva_access #(.RC_DIV(1), .WRITE_RC_CYCLES(8)) DUT (.clock(clock), .sys_rst(sys_rst), .io_req(io_req),
    .io_rdata(io_rdata), .global_irq_enable(global_irq_enable), .cpu_stall(cpu_stall), .ready_irq(ready_irq));
  // ---------------------------------------------------------------
  // compares, verdict and bus tasks
  // ---------------------------------------------------------------
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk8
  task automatic chk1(input logic got, input logic exp);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk1
  task automatic summarize();
    if (n_errors == 0 && comparisons > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : summarize
  // a stuck design must still reach the verdict
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      n_errors++;
      summarize();
    end
  end
  // strobe stays high so writes can go back to back
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    io_req <= {1'b1, 1'b0, a, d};
    @(posedge clock);
  endtask : wr
  // look at a register once the edge updates have landed
  task automatic rd(input logic [5:0] a, input logic [7:0] exp);
    io_req <= {1'b0, 1'b1, a, 8'h00};
    #1 chk8(io_rdata, exp);
    @(posedge clock);
  endtask : rd
  // halt must last exactly n cycles after the accepting edge
  task automatic stall(input int n);
    io_req.wr <= 1'b0;
    for (int i = 0; i < n; i++) begin
      #1 chk1(cpu_stall, 1'b1);
      @(posedge clock);
    end
    #1 chk1(cpu_stall, 1'b0);
    @(posedge clock);
  endtask : stall
  // upper address bits are driven high on purpose; only bit 0 counts
  task automatic set_addr(input logic [8:0] a);
    wr(OFS_ADDR_LOW, a[7:0]);
    wr(OFS_ADDR_HIGH, {7'h7f, a[8]});
  endtask : set_addr
  task automatic start_write(input logic [8:0] a, input logic [7:0] d, input logic [7:0] ie);
    set_addr(a);
    wr(OFS_DATA, d);
    wr(OFS_CONTROL, 8'h04 | ie);
    wr(OFS_CONTROL, 8'h02 | ie);
  endtask : start_write
  // poll the strobe bit; n counts edges since the accepting one
  task automatic wait_done(output int n);
    n = 3;
    // poll through the control register whatever was addressed last
    io_req <= {1'b0, 1'b1, OFS_CONTROL, 8'h00};
    #1 chk1(io_rdata[1], 1'b1);
    while (io_rdata[1] !== 1'b0 && n < 40) begin
      @(posedge clock);
      #1 n++;
    end
    chk1(io_rdata[1], 1'b0);
    @(posedge clock);
  endtask : wait_done
  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_reset();
    rd(OFS_CONTROL, CONTROL_RST);
    rd(OFS_DATA, DATA_RST);
    rd(OFS_ADDR_HIGH, 8'h00);
    rd(6'h23, 8'h00);
    stall(0);
  endtask : t_reset
  // writes at both ends of the array, then read all back
  task automatic t_rw();
    logic [8:0] a [3] = '{9'h000, 9'h1ff, 9'h0ab};
    logic [7:0] d [3] = '{8'h3c, 8'hc5, 8'h96};
    int n;
    for (int i = 0; i < 3; i++) begin
      start_write(a[i], d[i], 8'h00);
      stall(2);
      wait_done(n);
      chk1(n >= 7 && n <= 9, 1'b1);
    end
    for (int i = 0; i < 3; i++) begin
      set_addr(a[i]);
      rd(OFS_ADDR_HIGH, {7'h00, a[i][8]});
      wr(OFS_DATA, ~d[i]);
      wr(OFS_CONTROL, 8'h01);
      stall(4);
      rd(OFS_DATA, d[i]);
      rd(OFS_CONTROL, 8'h00);
    end
  endtask : t_rw
  task automatic t_no_enable();
    set_addr(9'h000);
    wr(OFS_DATA, 8'h11);
    wr(OFS_CONTROL, 8'h02);
    stall(0);
    rd(OFS_CONTROL, 8'h00);
    wr(OFS_CONTROL, 8'h01);
    stall(4);
    rd(OFS_DATA, 8'h3c);
  endtask : t_no_enable
  // strobe on the last allowed edge (k=3) and one edge late (k=4)
  task automatic t_window(input int k);
    int n;
    wr(OFS_CONTROL, 8'h04);
    io_req.wr <= 1'b0;
    for (int i = 0; i < k; i++) begin
      #1 chk8(io_rdata, 8'h04);
      @(posedge clock);
    end
    wr(OFS_CONTROL, 8'h02);
    stall(k < 4 ? 2 : 0);
    if (k < 4) wait_done(n);
    else rd(OFS_CONTROL, 8'h00);
  endtask : t_window
  // read strobe and address change during programming are refused
  task automatic t_busy();
    int n;
    start_write(9'h0ab, 8'h69, 8'h00);
    wr(OFS_DATA, 8'h44);
    wr(OFS_CONTROL, 8'h01);
    wr(OFS_ADDR_LOW, 8'h00);
    rd(OFS_ADDR_LOW, 8'hab);
    stall(0);
    rd(OFS_DATA, 8'h44);
    wait_done(n);
    set_addr(9'h0ab);
    wr(OFS_CONTROL, 8'h01);
    stall(4);
    rd(OFS_DATA, 8'h69);
  endtask : t_busy
  task automatic t_irq();
    int n;
    global_irq_enable <= 1'b1;
    wr(OFS_CONTROL, 8'h08);
    io_req.wr <= 1'b0;
    #1 chk1(ready_irq, 1'b1);
    @(posedge clock);
    global_irq_enable <= 1'b0;
    #1 chk1(ready_irq, 1'b0);
    @(posedge clock);
    global_irq_enable <= 1'b1;
    start_write(9'h1ff, 8'h5a, 8'h08);
    io_req.wr <= 1'b0;
    #1 chk1(ready_irq, 1'b0);
    @(posedge clock);
    wait_done(n);
    #1 chk1(ready_irq, 1'b1);
    @(posedge clock);
    wr(OFS_CONTROL, 8'h00);
    io_req.wr <= 1'b0;
    #1 chk1(ready_irq, 1'b0);
    @(posedge clock);
  endtask : t_irq
  initial begin
    repeat (5) @(posedge clock);
    sys_rst <= 1'b0;
    repeat (2) @(posedge clock);
    t_reset();
    t_rw();
    t_no_enable();
    t_window(3);
    t_window(4);
    t_busy();
    t_irq();
    summarize();
  end
endmodule : tb
